// File: design/vic_pkg.sv
// Constants, register map and carrier types of the vectored interrupt controller.
// Assumes a 32-bit APB register bus and one system clock.
package vic_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_SRC = 64;
  localparam int NUM_VEC = 44;
  localparam int NUM_PRIO_REG = 11;
  localparam int NUM_EXT = 5;
  localparam int EXT_IRQ_FIRST = 3;
  localparam int EXT_IRQ_STEP = 5;
  localparam int TIMER_IRQ = 0;
  localparam int CAPT_ERR_IRQ = 5;
  localparam int CAPT_IRQ = 6;
  localparam int CONV_IRQ = 28;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h010;
  localparam logic [11:0] OFF_FLAG_LO = 12'h030;
  localparam logic [11:0] OFF_FLAG_HI = 12'h040;
  localparam logic [11:0] OFF_EN_LO = 12'h060;
  localparam logic [11:0] OFF_EN_HI = 12'h070;
  localparam logic [11:0] OFF_PRIO0 = 12'h090;
  localparam logic [11:0] OFF_PRIO_END = 12'h140;
  localparam logic [11:0] OFF_VBASE = 12'h200;
  localparam logic [11:0] OFF_VSPACE = 12'h210;

  // ==========================================================================
  // Field layout and reset values
  localparam int CTRL_MVEC = 12;
  localparam int STAT_IPL_LSB = 8;
  localparam int PRIO_SLOT_W = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000101f;
  localparam logic [31:0] PRIO_MASK = 32'h1f1f1f1f;
  localparam logic [31:0] VBASE_MASK = 32'hfffffffc;
  localparam logic [31:0] VSPACE_MASK = 32'h0000fffc;
  localparam logic [31:0] VBASE_RST = 32'h00000000;
  localparam logic [31:0] VSPACE_RST = 32'h00000020;

  // ==========================================================================
  // Source tables
  localparam logic [63:0] PERSIST_MASK = 64'h0ffffff816318c60;
  localparam logic [63:0][5:0] VEC_MAP = {
    6'h2b, 6'h2a, 6'h29, 6'h28, 6'h27, 6'h26, 6'h26, 6'h26,
    6'h25, 6'h25, 6'h25, 6'h24, 6'h24, 6'h24, 6'h23, 6'h23,
    6'h22, 6'h22, 6'h22, 6'h21, 6'h21, 6'h21, 6'h20, 6'h20,
    6'h20, 6'h1f, 6'h1f, 6'h1f, 6'h1e, 6'h1d, 6'h1c, 6'h1b,
    6'h1a, 6'h19, 6'h18, 6'h17, 6'h16, 6'h15, 6'h15, 6'h14,
    6'h13, 6'h12, 6'h11, 6'h11, 6'h10, 6'h0f, 6'h0e, 6'h0d,
    6'h0d, 6'h0c, 6'h0b, 6'h0a, 6'h09, 6'h09, 6'h08, 6'h07,
    6'h06, 6'h05, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00};

  // ==========================================================================
  // Request presented to the processor
  typedef struct packed {
    logic req;
    logic [5:0] vec;
    logic [2:0] ipl;
    logic [31:0] addr;
  } vic_cpu_t;

endpackage

// File: design/vic_top.sv
// Vectored interrupt controller with an APB register slave.
// Assumes APB signals, source requests and pins synchronous to pclk.
//
// Functional notes
// - Up to 64 request sources, each with its own request number.
// - Sources map onto at most 44 vectors, some vectors shared.
// - Single-vector mode uses one common vector; multi-vector uses assigned vectors.
// - Five external pins, each with selectable edge polarity setting its flag.
// - Each vector has a priority of seven active levels deciding presentation.
// - Four subpriority levels order vectors of equal priority.
// - A software write of a flag acts like a hardware event.
// - Priority resolved outside the CPU before the winner is presented.
// - No shadow register set is provided or selected.
// - Vector table base is software configurable.
// - Vector spacing is software configurable; addresses computed from it.
// - Core timer is request 0, vector 0, bit 0, fields 4:2/1:0.
// - Each priority register holds four vector slots; slot four serves pin 0.
// - Capture one error and event share vector 5 and one field pair.
// - Serial one fault, receive, transmit share vector 31; receive at high bit 5.
// - Converter done and marked capture, serial, USB sources are persistent.
// - USB is request 35, vector 30, high bit 3, persistent.
// - Requests 32 and up use the high flag and enable registers.
`timescale 1ns/1ps
`default_nettype none

module vic_top #(
  parameter int NSRC = 64,
  parameter int NVEC = 44
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [63:0] src_req,
  input wire logic [4:0] ext_pin,
  output vic_pkg::vic_cpu_t cpu
);
  import vic_pkg::*;

  // ==========================================================================
  // Elaboration check
  if (NSRC != NUM_SRC || NVEC != NUM_VEC) begin : g_chk
    $error("vic_top serves only the fixed 64-source, 44-vector map.");
  end

  // ==========================================================================
  // State
  logic [63:0] flag_r;
  logic [63:0] flag_nxt;
  logic [63:0] en_r;
  logic [63:0] src_q_r;
  logic [63:0] set_ev;
  logic [4:0] ext_q_r;
  logic [4:0] ext_edge;
  logic [31:0] ctrl_r;
  logic [31:0] vbase_r;
  logic [31:0] vspace_r;
  logic [NUM_PRIO_REG-1:0][31:0] prio_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [31:0] rdata;
  logic hit;
  logic wr_acc;
  logic rd_setup;
  logic [4:0] best_key;
  logic [4:0] key;
  logic [5:0] best_irq;
  logic found;
  logic [5:0] win_vec;
  vic_cpu_t cpu_r;

  // ==========================================================================
  // Helpers

  // Priority and subpriority of a vector; four slots per register.
  function automatic logic [4:0] vfield(input logic [5:0] v,
                                        input logic [NUM_PRIO_REG-1:0][31:0] regs);
    logic [31:0] w;
    w = regs[v[5:2]];
    return w[PRIO_SLOT_W*v[1:0] +: 5];
  endfunction

  // True when the address hits one of the priority registers.
  function automatic logic is_prio(input logic [11:0] a);
    return a >= OFF_PRIO0 && a < OFF_PRIO_END && a[3:0] == 4'h0;
  endfunction

  // Index of the priority register at an address.
  function automatic logic [3:0] prio_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - OFF_PRIO0;
    return d[7:4];
  endfunction

  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  // ==========================================================================
  // Event capture

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q_r <= 64'h0;
      ext_q_r <= 5'h0;
    end else begin
      src_q_r <= src_req;
      ext_q_r <= ext_pin;
    end
  end

  // Polarity bit set selects the rising edge, clear the falling edge.
  always_comb begin
    for (int k = 0; k < NUM_EXT; k++) begin
      if (ctrl_r[k]) begin
        ext_edge[k] = ext_pin[k] && !ext_q_r[k];
      end else begin
        ext_edge[k] = !ext_pin[k] && ext_q_r[k];
      end
    end
  end

  // Persistent sources set while their level stays high; others on a rising edge.
  always_comb begin
    set_ev = (src_req & PERSIST_MASK) | (src_req & ~src_q_r & ~PERSIST_MASK);
    for (int k = 0; k < NUM_EXT; k++) begin
      set_ev[EXT_IRQ_FIRST + EXT_IRQ_STEP*k] = set_ev[EXT_IRQ_FIRST + EXT_IRQ_STEP*k] | ext_edge[k];
    end
  end

  // ==========================================================================
  // Flags: a write stores the written value, then events are merged so set wins.

  always_comb begin
    flag_nxt = flag_r;
    if (wr_acc && paddr == OFF_FLAG_LO) begin
      flag_nxt[31:0] = pwdata;
    end
    if (wr_acc && paddr == OFF_FLAG_HI) begin
      flag_nxt[63:32] = pwdata;
    end
    flag_nxt = flag_nxt | set_ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 64'h0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // ==========================================================================
  // Configuration registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 64'h0;
    end else if (wr_acc && paddr == OFF_EN_LO) begin
      en_r[31:0] <= pwdata;
    end else if (wr_acc && paddr == OFF_EN_HI) begin
      en_r[63:32] <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 32'h0;
    end else if (wr_acc && paddr == OFF_CTRL) begin
      ctrl_r <= pwdata & CTRL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbase_r <= VBASE_RST;
      vspace_r <= VSPACE_RST;
    end else if (wr_acc && paddr == OFF_VBASE) begin
      vbase_r <= pwdata & VBASE_MASK;
    end else if (wr_acc && paddr == OFF_VSPACE) begin
      vspace_r <= pwdata & VSPACE_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_r <= '0;
    end else if (wr_acc && is_prio(paddr)) begin
      prio_r[prio_idx(paddr)] <= pwdata & PRIO_MASK;
    end
  end

  // ==========================================================================
  // Priority resolution

  // Descending scan with a non-strict compare lets the lowest request win ties.
  always_comb begin
    best_key = 5'h0;
    best_irq = 6'h0;
    found = 1'h0;
    key = 5'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      key = vfield(VEC_MAP[i], prio_r);
      if (flag_r[i] && en_r[i] && key[4:2] != 3'h0 && key >= best_key) begin
        best_key = key;
        best_irq = 6'(i);
        found = 1'h1;
      end
    end
  end

  assign win_vec = ctrl_r[CTRL_MVEC] ? VEC_MAP[best_irq] : 6'h00;

  // Only the resolved winner reaches the processor port; no register set select exists.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_r <= '0;
    end else begin
      cpu_r.req <= found;
      cpu_r.vec <= win_vec;
      cpu_r.ipl <= best_key[4:2];
      cpu_r.addr <= vbase_r + ({26'h0, win_vec} * vspace_r);
    end
  end

  assign cpu = cpu_r;

  // ==========================================================================
  // APB slave: data captured in setup, answer in the first access cycle.

  always_comb begin
    rdata = 32'h0;
    hit = 1'h1;
    if (is_prio(paddr)) begin
      rdata = prio_r[prio_idx(paddr)];
    end else begin
      case (paddr)
        OFF_CTRL: rdata = ctrl_r;
        OFF_STAT: rdata = {21'h0, cpu_r.ipl, 2'h0, cpu_r.vec};
        OFF_FLAG_LO: rdata = flag_r[31:0];
        OFF_FLAG_HI: rdata = flag_r[63:32];
        OFF_EN_LO: rdata = en_r[31:0];
        OFF_EN_HI: rdata = en_r[63:32];
        OFF_VBASE: rdata = vbase_r;
        OFF_VSPACE: rdata = vspace_r;
        default: hit = 1'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
      pslverr_r <= 1'h0;
    end else if (rd_setup) begin
      prdata_r <= pwrite ? 32'h0 : rdata;
      pslverr_r <= !hit;
    end
  end

  assign prdata = prdata_r;
  assign pready = penable;
  assign pslverr = pslverr_r && penable;

  // ==========================================================================
  // Assertions

  property p_sw_set;
    @(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == OFF_FLAG_LO |=> (flag_r[31:0] & $past(pwdata)) == $past(pwdata);
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("Software flag write did not set the flag.");

  property p_ext_edge;
    @(posedge pclk) disable iff (!presetn)
    ctrl_r[0] && ext_pin[0] && !ext_q_r[0] |=> flag_r[EXT_IRQ_FIRST];
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("External edge did not set its flag.");

  property p_ipl;
    @(posedge pclk) disable iff (!presetn)
    cpu.req |-> cpu.ipl != 3'h0 && cpu.ipl == $past(best_key[4:2]);
  endproperty
  a_ipl: assert property (p_ipl) else $error("Presented priority level is wrong.");

  property p_single;
    @(posedge pclk) disable iff (!presetn)
    !ctrl_r[CTRL_MVEC] ##1 cpu.req |-> cpu.vec == 6'h00;
  endproperty
  a_single: assert property (p_single) else $error("Single-vector mode gave a nonzero vector.");

  property p_req_cause;
    @(posedge pclk) disable iff (!presetn)
    cpu.req |-> $past(|(flag_r & en_r));
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("Request without an enabled pending flag.");

  property p_persist;
    @(posedge pclk) disable iff (!presetn)
    src_req[CONV_IRQ] |=> flag_r[CONV_IRQ];
  endproperty
  a_persist: assert property (p_persist) else $error("Persistent flag not held set.");

  property p_addr;
    @(posedge pclk) disable iff (!presetn)
    cpu.req |-> cpu.addr == $past(vbase_r) + ({26'h0, cpu.vec} * $past(vspace_r));
  endproperty
  a_addr: assert property (p_addr) else $error("Vector address does not follow base and spacing.");

  property p_timer;
    @(posedge pclk) disable iff (!presetn)
    flag_r == 64'h1 && en_r[TIMER_IRQ] && prio_r[0][4:2] != 3'h0 && ctrl_r[CTRL_MVEC]
      |=> cpu.req && cpu.vec == 6'h00 && cpu.ipl == $past(prio_r[0][4:2]);
  endproperty
  a_timer: assert property (p_timer) else $error("Core timer not presented on vector 0.");

  property p_shared;
    @(posedge pclk) disable iff (!presetn)
    (flag_r & en_r & ~((64'h1 << CAPT_ERR_IRQ) | (64'h1 << CONV_IRQ))) == (64'h1 << CAPT_IRQ)
      && prio_r[1][12:10] != 3'h0
      && prio_r[5][28:26] == 3'h0
      && ctrl_r[CTRL_MVEC]
      |=> cpu.req && cpu.vec == 6'h05;
  endproperty
  a_shared: assert property (p_shared) else $error("Capture event not presented on vector 5.");

  property p_tie;
    @(posedge pclk) disable iff (!presetn)
    (flag_r & en_r & ~(64'h1 << CONV_IRQ)) == ((64'h1 << CAPT_ERR_IRQ) | (64'h1 << CAPT_IRQ))
      && prio_r[1][12:10] != 3'h0
      && prio_r[5][28:26] == 3'h0
      |-> found && best_irq == 6'h05;
  endproperty
  a_tie: assert property (p_tie) else $error("Tie not resolved to the lowest request.");

endmodule

`default_nettype wire

// File: verification/vic_core_model.sv
// Processor-side model that takes the request presented by the controller.
// Assumes the registered cpu carrier of the controller, on pclk.
`timescale 1ns/1ps
`default_nettype none

module vic_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire vic_pkg::vic_cpu_t cpu,
  output logic [5:0] taken_vec,
  output logic [31:0] taken_addr
);
  import vic_pkg::*;

  // ==========================================================================
  // Take vector
  // The core acts only on what the controller has already resolved.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taken_vec <= 6'h00;
      taken_addr <= 32'h00000000;
    end else if (cpu.req) begin
      taken_vec <= cpu.vec;
      taken_addr <= cpu.addr;
    end
  end
endmodule

`default_nettype wire

// File: verification/vectored_interrupt_controller_bench.sv
// Self-checking bench for the vectored interrupt controller.
// Assumes vic_top, vic_pkg and vic_core_model compiled before it.
`timescale 1ns/1ps
`default_nettype none

module vectored_interrupt_controller_bench;
  import vic_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, taken_addr;
  logic [63:0] src_req;
  logic [4:0] ext_pin;
  logic [5:0] taken_vec;
  vic_cpu_t cpu;
  int miscompares = 0;
  int check_count = 0;

  vic_top i_vic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_req(src_req), .ext_pin(ext_pin), .cpu(cpu));
  vic_core_model i_vic_core_model (.pclk(pclk), .presetn(presetn), .cpu(cpu), .taken_vec(taken_vec),
    .taken_addr(taken_addr));

  // ==========================================================================
  // Clock, checks and closing
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    finish_test();
  end

  // ==========================================================================
  // APB master
  // Entered just after a rising edge; leaves one idle edge so psel is never driven twice at once.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask

  // Looks at the registered carrier once the edge's updates have landed.
  task automatic cpu_chk(input logic [5:0] v, input logic [2:0] l, input logic [31:0] ad);
    repeat (3) @(posedge pclk);
    #1;
    check(cpu.req, 1'b1);
    check(cpu.vec, v);
    check(cpu.ipl, l);
    check(cpu.addr, ad);
    @(posedge pclk);
  endtask

  // ==========================================================================
  // Scenarios
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    src_req = 64'h0;
    ext_pin = 5'h1f;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(OFF_CTRL, 32'h00000000);
    rdchk(OFF_VSPACE, 32'h00000020);
    rdchk(OFF_VBASE, 32'h00000000);
    apb(1'b0, 12'h300, 32'h00000000);
    check(err, 1'b1);
    check(rd, 32'h00000000);
    wr(OFF_VBASE, 32'h00001000);
    wr(OFF_VSPACE, 32'h00000040);
    wr(OFF_CTRL, 32'h00001000);
    wr(OFF_EN_LO, 32'hffffffff);
    wr(OFF_EN_HI, 32'hffffffff);
    #1;
    check(cpu.req, 1'b0);
    @(posedge pclk);
    wr(OFF_PRIO0, 32'h00000004);
    wr(OFF_FLAG_LO, 32'h00000001);
    cpu_chk(6'h00, 3'h1, 32'h00001000);
    wr(OFF_PRIO0, 32'h0c000004);
    ext_pin[0] <= 1'b0;
    cpu_chk(6'h03, 3'h3, 32'h000010c0);
    rdchk(OFF_FLAG_LO, 32'h00000009);
    wr(OFF_PRIO0 + 12'h010, 32'h00000e0d);
    src_req[5] <= 1'b1;
    src_req[6] <= 1'b1;
    src_req[28] <= 1'b1;
    src_req[4] <= 1'b1;
    @(posedge pclk);
    src_req[4] <= 1'b0;
    cpu_chk(6'h05, 3'h3, 32'h00001140);
    rdchk(OFF_FLAG_LO, 32'h10000079);
    wr(OFF_PRIO0 + 12'h010, 32'h00000c0c);
    cpu_chk(6'h03, 3'h3, 32'h000010c0);
    wr(OFF_FLAG_LO, 32'h00000000);
    rdchk(OFF_FLAG_LO, 32'h10000060);
    src_req[5] <= 1'b0;
    src_req[6] <= 1'b0;
    src_req[28] <= 1'b0;
    @(posedge pclk);
    wr(OFF_FLAG_LO, 32'h00000000);
    rdchk(OFF_FLAG_LO, 32'h00000000);
    #1;
    check(cpu.req, 1'b0);
    @(posedge pclk);
    src_req[32] <= 1'b1;
    src_req[35] <= 1'b1;
    src_req[37] <= 1'b1;
    @(posedge pclk);
    src_req <= 64'h0;
    rdchk(OFF_FLAG_HI, 32'h00000029);
    wr(OFF_PRIO0 + 12'h070, 32'h1c000000);
    cpu_chk(6'h1f, 3'h7, 32'h000017c0);
    check(taken_vec, 6'h1f);
    check(taken_addr, 32'h000017c0);
    rdchk(OFF_STAT, 32'h0000071f);
    wr(OFF_FLAG_HI, 32'h00000001);
    rdchk(OFF_FLAG_HI, 32'h00000001);
    wr(OFF_PRIO0 + 12'h060, 32'h1c000000);
    wr(OFF_CTRL, 32'h00000001);
    cpu_chk(6'h00, 3'h7, 32'h00001000);
    ext_pin[0] <= 1'b1;
    repeat (3) @(posedge pclk);
    rdchk(OFF_FLAG_LO, 32'h00000008);
    ext_pin[4] <= 1'b0;
    repeat (3) @(posedge pclk);
    rdchk(OFF_FLAG_LO, 32'h00800008);
    finish_test();
  end
endmodule

`default_nettype wire
